// ---- logic/cmc_pkg.sv ----
// package: constants for the cache mode control block
package cmc_pkg;
  // register byte offsets
  localparam logic [3:0] CMC_OFF_CTRL = 4'h0;
  localparam logic [3:0] CMC_OFF_STAT = 4'h4;
  localparam logic [3:0] CMC_OFF_MASK = 4'h8;
  // control register fields
  localparam int CMC_CTRL_CD = 0;
  localparam int CMC_CTRL_NW = 1;
  localparam logic [1:0] CMC_CTRL_RST = 2'h3;
  // status/mask bit positions
  localparam int CMC_EV_FAULT = 0;
  localparam int CMC_EV_FILL = 1;
  localparam int CMC_EV_WMISS = 2;
  localparam int CMC_EV_WRITE = 3;
  localparam int CMC_EV_W = 4;
  localparam logic [3:0] CMC_MASK_RST = 4'h0;
  // cache geometry
  localparam int CMC_SETS = 16;
  localparam int CMC_IDX_W = 4;
  localparam int CMC_TAG_W = 8;
  localparam int CMC_DATA_W = 32;
  // line states
  typedef enum logic [1:0] {
    CMC_INV = 2'h0,
    CMC_SHR = 2'h1,
    CMC_EXC = 2'h3,
    CMC_MOD = 2'h2
  } cmc_line_t;
  // access kinds
  typedef enum logic [1:0] {
    CMC_OP_READ = 2'h0,
    CMC_OP_WRITE = 2'h1,
    CMC_OP_SNOOP = 2'h3
  } cmc_op_t;
endpackage : cmc_pkg

// ---- logic/cmc_mode_decode.sv ----
// mode decode: turns the two cache flags into per-access policy
`timescale 1ns/1ps
module cmc_mode_decode
  import cmc_pkg::*;
(
  input wire logic cd,
  input wire logic nw,
  input wire logic wt_variant,
  output logic alloc_en,
  output logic snoop_en,
  output logic wr_hit_quiet,
  output logic wt_all
);
  assign alloc_en = ~cd;
  assign snoop_en = ~(cd & nw);
  assign wr_hit_quiet = cd & nw;
  assign wt_all = wt_variant & ~nw;
endmodule : cmc_mode_decode

// ---- logic/cmc_top.sv ----
// cache mode control: line state directory, write policy and Avalon registers
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module cmc_top
  import cmc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // build option
  input wire logic WT_VARIANT,
  // avalon slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // core access
  input wire logic ACC_VALID,
  input wire logic [1:0] ACC_OP,
  input wire logic [CMC_IDX_W-1:0] ACC_INDEX,
  input wire logic [CMC_TAG_W-1:0] ACC_TAG,
  input wire logic [CMC_DATA_W-1:0] ACC_WDATA,
  input wire logic SNOOP_INVAL,
  input wire logic LINE_POLICY_SELECT_PIN,
  // access results
  output logic ACC_HIT,
  output logic [CMC_DATA_W-1:0] ACC_RDATA,
  output logic ACC_DONE,
  output logic EXT_WRITE,
  output logic EXT_FILL,
  output logic [1:0] ACC_LINE_STATE,
  // events
  output logic PROTECTION_FAULT,
  output logic IRQ
);
  logic cache_disable_flag;
  logic no_write_through_flag;
  logic [CMC_EV_W-1:0] status;
  logic [CMC_EV_W-1:0] mask;
  logic bus_ack;
  cmc_line_t line_state [CMC_SETS];
  logic [CMC_TAG_W-1:0] line_tag [CMC_SETS];
  logic [CMC_DATA_W-1:0] line_data [CMC_SETS];

  logic alloc_en, snoop_en, wr_hit_quiet, wt_all;
  cmc_mode_decode u_dec (
    .cd(cache_disable_flag),
    .nw(no_write_through_flag),
    .wt_variant(WT_VARIANT),
    .alloc_en(alloc_en),
    .snoop_en(snoop_en),
    .wr_hit_quiet(wr_hit_quiet),
    .wt_all(wt_all)
  );

  // bus decode: one wait cycle then ack
  wire bus_req = (AVS_READ | AVS_WRITE) & ~bus_ack;
  wire sel_ctrl = AVS_ADDRESS == CMC_OFF_CTRL;
  wire sel_stat = AVS_ADDRESS == CMC_OFF_STAT;
  wire sel_mask = AVS_ADDRESS == CMC_OFF_MASK;
  wire wr_ctrl = bus_ack & AVS_WRITE & sel_ctrl & AVS_BYTEENABLE[0];
  wire wr_mask = bus_ack & AVS_WRITE & sel_mask & AVS_BYTEENABLE[0];
  wire rd_stat = bus_ack & AVS_READ & sel_stat;
  wire new_cd = AVS_WRITEDATA[CMC_CTRL_CD];
  wire new_nw = AVS_WRITEDATA[CMC_CTRL_NW];
  wire bad_combo = wr_ctrl & ~new_cd & new_nw;
  wire [31:0] next_rdata = sel_ctrl ? {30'h0, no_write_through_flag, cache_disable_flag} :
                           sel_stat ? {28'h0, status} :
                           sel_mask ? {28'h0, mask} : 32'h0;

  // access decode
  wire op_read = ACC_VALID & (ACC_OP == CMC_OP_READ);
  wire op_write = ACC_VALID & (ACC_OP == CMC_OP_WRITE);
  wire op_snoop = ACC_VALID & (ACC_OP == CMC_OP_SNOOP);
  cmc_line_t cur;
  assign cur = line_state[ACC_INDEX];
  wire hit = (cur != CMC_INV) & (line_tag[ACC_INDEX] == ACC_TAG);
  wire do_fill = op_read & ~hit & alloc_en;
  // external write decision per variant and mode
  wire wb_ext = ~hit | (cur == CMC_SHR);
  wire wr_ext = op_write & (wr_hit_quiet ? ~hit :
                            (wt_all | wb_ext));
  wire fill_excl = ~WT_VARIANT & LINE_POLICY_SELECT_PIN;
  cmc_line_t next_fill;
  assign next_fill = fill_excl ? CMC_EXC : CMC_SHR;
  cmc_line_t next_wstate;
  always_comb begin
    next_wstate = cur;
    if (WT_VARIANT) begin
      next_wstate = cur;
    end else if (wr_hit_quiet) begin
      if (cur == CMC_EXC) begin
        next_wstate = CMC_MOD;
      end else begin
        next_wstate = cur;
      end
    end else if (cur == CMC_SHR) begin
      next_wstate = LINE_POLICY_SELECT_PIN ? CMC_EXC : CMC_SHR;
    end else if (cur == CMC_EXC) begin
      next_wstate = CMC_MOD;
    end
  end
  wire do_inval = op_snoop & SNOOP_INVAL & hit & snoop_en;
  wire [CMC_EV_W-1:0] events = {wr_ext, op_write & ~hit, do_fill, bad_combo};

  // control flags; the illegal combination leaves them untouched
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cache_disable_flag <= CMC_CTRL_RST[CMC_CTRL_CD];
      no_write_through_flag <= CMC_CTRL_RST[CMC_CTRL_NW];
    end else if (wr_ctrl & ~bad_combo) begin
      cache_disable_flag <= new_cd;
      no_write_through_flag <= new_nw;
    end
  end

  // sticky status: a set in the read cycle survives the clear
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      status <= '0;
      mask <= CMC_MASK_RST;
    end else begin
      status <= (rd_stat ? '0 : status) | events;
      if (wr_mask) begin
        mask <= AVS_WRITEDATA[CMC_EV_W-1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      bus_ack <= 1'b0;
      AVS_READDATA <= 32'h0;
      AVS_WAITREQUEST <= 1'b1;
      IRQ <= 1'b0;
      PROTECTION_FAULT <= 1'b0;
    end else begin
      bus_ack <= bus_req;
      AVS_WAITREQUEST <= ~bus_req;
      if (bus_req & AVS_READ) begin
        AVS_READDATA <= next_rdata;
      end
      IRQ <= |((status | events) & mask);
      PROTECTION_FAULT <= bad_combo;
    end
  end

  // line directory
  genvar g;
  for (g = 0; g < CMC_SETS; g++) begin : g_line
    wire here = ACC_INDEX == CMC_IDX_W'(g);
    always_ff @(posedge REF_CLK) begin
      if (RESET) begin
        line_state[g] <= CMC_INV;
        line_tag[g] <= '0;
        line_data[g] <= '0;
      end else if (here & do_fill) begin
        line_state[g] <= next_fill;
        line_tag[g] <= ACC_TAG;
      end else if (here & op_write & hit) begin
        line_state[g] <= next_wstate;
        line_data[g] <= ACC_WDATA;
      end else if (here & do_inval) begin
        line_state[g] <= CMC_INV;
      end
    end
  end

  // access result, one cycle after the request
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ACC_HIT <= 1'b0;
      ACC_RDATA <= '0;
      ACC_DONE <= 1'b0;
      EXT_WRITE <= 1'b0;
      EXT_FILL <= 1'b0;
      ACC_LINE_STATE <= 2'h0;
    end else begin
      ACC_DONE <= ACC_VALID;
      ACC_HIT <= ACC_VALID & hit;
      ACC_RDATA <= (op_read & hit) ? line_data[ACC_INDEX] : '0;
      EXT_WRITE <= wr_ext;
      EXT_FILL <= do_fill;
      ACC_LINE_STATE <= do_fill ? next_fill : (op_write & hit) ? next_wstate :
                        do_inval ? CMC_INV : cur;
    end
  end

  // checks
  property p_excl_mod;
    @(posedge REF_CLK) disable iff (RESET)
      (op_write & hit & wr_hit_quiet & ~WT_VARIANT & cur == CMC_EXC)
        |=> ACC_LINE_STATE == CMC_MOD;
  endproperty
  excl_to_mod_a: assert property (p_excl_mod) else $error("exclusive hit not modified");
  shared_stays_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_write & hit & wr_hit_quiet & cur == CMC_SHR) |=> ACC_LINE_STATE == CMC_SHR)
    else $error("shared line changed");
  quiet_hit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_write & hit & cache_disable_flag & no_write_through_flag) |=> !EXT_WRITE)
    else $error("quiet write hit went external");
  miss_ext_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_write & ~hit) |=> EXT_WRITE)
    else $error("write miss not external");
  no_alloc_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (ACC_VALID & cache_disable_flag) |=> !EXT_FILL)
    else $error("fill while disabled");
  sequence s_bad_write;
    wr_ctrl & ~new_cd & new_nw;
  endsequence
  fault_keep_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_bad_write |=> PROTECTION_FAULT && $stable(cache_disable_flag)
      && $stable(no_write_through_flag))
    else $error("illegal flags accepted");
  reset_flags_a: assert property (@(posedge REF_CLK)
    $past(RESET) |-> cache_disable_flag && no_write_through_flag)
    else $error("flags wrong after reset");
  wt_all_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_write & WT_VARIANT & ~no_write_through_flag) |=> EXT_WRITE)
    else $error("write-through store not external");
  snoop_ign_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_snoop & cache_disable_flag & no_write_through_flag) |=> ACC_LINE_STATE == $past(cur))
    else $error("snoop changed line");
  fill_pin_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (do_fill & ~WT_VARIANT) |=> ACC_LINE_STATE == ($past(LINE_POLICY_SELECT_PIN) ? CMC_EXC : CMC_SHR))
    else $error("fill state ignores pin");

  // access and bus steps, shared by the checks below
  sequence s_wr_hit;
    op_write & hit;
  endsequence
  sequence s_rd_miss;
    op_read & ~hit;
  endsequence
  sequence s_bus_req;
    (AVS_READ | AVS_WRITE) & ~bus_ack;
  endsequence

  done_pulse_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    ACC_VALID
      |=> ACC_DONE)
    else $error("access not answered");
  fill_alloc_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_rd_miss ##0 !cache_disable_flag
      |=> EXT_FILL)
    else $error("read miss did not allocate");
  rd_hit_data_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_read & hit)
      |=> ACC_HIT && ACC_RDATA == $past(line_data[ACC_INDEX]))
    else $error("read hit data wrong");
  shr_to_exc_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_wr_hit ##0 (!wr_hit_quiet && !WT_VARIANT && cur == CMC_SHR && LINE_POLICY_SELECT_PIN)
      |=> ACC_LINE_STATE == CMC_EXC)
    else $error("shared write did not go exclusive");
  wb_hit_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_wr_hit ##0 (!WT_VARIANT && !cache_disable_flag && cur != CMC_SHR)
      |=> !EXT_WRITE)
    else $error("owned write hit went external");
  shr_ext_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_wr_hit ##0 (cache_disable_flag && !no_write_through_flag && cur == CMC_SHR)
      |=> EXT_WRITE)
    else $error("shared write not external");
  wt_cd_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_write & WT_VARIANT & cache_disable_flag & ~no_write_through_flag)
      |=> EXT_WRITE)
    else $error("write-through store kept internal");
  snoop_inval_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_snoop & SNOOP_INVAL & hit & ~(cache_disable_flag & no_write_through_flag))
      |=> ACC_LINE_STATE == CMC_INV)
    else $error("invalidation ignored");
  lock_no_fill_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (op_read & cache_disable_flag & no_write_through_flag)
      |=> !EXT_FILL)
    else $error("fill with both flags set");
  wt_fill_shr_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (do_fill & WT_VARIANT)
      |=> ACC_LINE_STATE == CMC_SHR)
    else $error("write-through fill not shared");
  flags_legal_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !(!cache_disable_flag && no_write_through_flag))
    else $error("illegal flag pair held");
  fault_stat_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_bad_write
      |=> status[CMC_EV_FAULT])
    else $error("fault not recorded");
  miss_no_hit_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (ACC_VALID & ~hit)
      |=> !ACC_HIT)
    else $error("miss reported as hit");
  rdata_zero_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !(op_read & hit)
      |=> ACC_RDATA == '0)
    else $error("read data without read hit");
  idle_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !ACC_VALID
      |=> !ACC_DONE && !EXT_WRITE && !EXT_FILL)
    else $error("result without access");
  irq_level_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (|(status & mask))
      |=> IRQ)
    else $error("unmasked event without interrupt");
  stat_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    (rd_stat & ~|events)
      |=> status == '0)
    else $error("status not cleared by read");
  mask_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    wr_mask
      |=> mask == $past(AVS_WRITEDATA[CMC_EV_W-1:0]))
    else $error("mask write lost");
  wait_low_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_bus_req
      |=> !AVS_WAITREQUEST)
    else $error("request not answered");
  wait_high_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !bus_req
      |=> AVS_WAITREQUEST)
    else $error("waitrequest low without request");
endmodule : cmc_top

// ---- bench/cmc_bus_agent.sv ----
// far-side bus agent model: drives the line policy pin during accesses
`timescale 1ns/1ps
module cmc_bus_agent (
  // access strobe seen on the bus
  input wire logic acc_valid,
  // policy the bench wants granted
  input wire logic want_excl,
  // policy pin toward the device
  output logic policy_pin
);
  // outside an access the pin flips, so a stale level is never relied on
  assign policy_pin = acc_valid ? want_excl : ~want_excl;
endmodule : cmc_bus_agent

// ---- bench/cache_mode_control_bench.sv ----
// bench for cache mode control: registers, interrupt, modes and snoops
`timescale 1ns/1ps
module cache_mode_control_bench;
  import cmc_pkg::*;
  localparam logic [3:0] d = 4'h8, dh = 4'hc, dhw = 4'he, dw = 4'ha, df = 4'h9;
  localparam logic [1:0] rd_op = 2'h0, wr_op = 2'h1, sn_op = 2'h3;
  logic ref_clk = 0, reset = 1, wt = 0, rd = 0, wr = 0, vld = 0, excl = 0, pin;
  logic wq, hit, done, extw, extf, irq, pf;
  logic [3:0] adr = 4'h0, idx = 4'h0;
  logic [7:0] tag = 8'h0;
  logic [1:0] op = 2'h0, st;
  logic [31:0] wdat = 32'h0, rdat, ard, q;
  int miscompares = 0, checks = 0;
  initial forever #20 ref_clk = ~ref_clk;
  cmc_top cmc_top_inst (.REF_CLK(ref_clk), .RESET(reset), .WT_VARIANT(wt),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .ACC_VALID(vld),
    .ACC_OP(op), .ACC_INDEX(idx), .ACC_TAG(tag), .ACC_WDATA(wdat), .SNOOP_INVAL(1'b1),
    .LINE_POLICY_SELECT_PIN(pin), .ACC_HIT(hit), .ACC_RDATA(ard), .ACC_DONE(done),
    .EXT_WRITE(extw), .EXT_FILL(extf), .ACC_LINE_STATE(st), .PROTECTION_FAULT(pf),
    .IRQ(irq));
  cmc_bus_agent cmc_bus_agent_inst (.acc_valid(vld), .want_excl(excl), .policy_pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= dat;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (wq !== 1'b0 && n < 20);
    // the edge that sees waitrequest low completes the transfer
    @(posedge ref_clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) miscompares++;
  endtask : av
  // exp packs done, hit, ext write, fill, state; all ones leaves a snoop unjudged
  task automatic acc(input logic [1:0] o, input logic [3:0] i, input logic [7:0] t,
                     input logic p, input logic [5:0] exp);
    @(posedge ref_clk);
    vld <= 1'b1;
    op <= o;
    idx <= i;
    tag <= t;
    excl <= p;
    wdat <= {t, t, t, t};
    @(posedge ref_clk);
    vld <= 1'b0;
    #1;
    if (exp !== 6'h3f) chk({26'h0, done, hit, extw, extf, st}, {26'h0, exp});
  endtask : acc
  task automatic t_reset();
    av(0, CMC_OFF_CTRL, 32'h0);
    chk(q, 32'h3);
    av(0, CMC_OFF_MASK, 32'h0);
    chk(q, 32'h0);
    av(0, 4'hc, 32'h0);
    chk(q, 32'h0);
  endtask : t_reset
  task automatic t_fault();
    av(1, CMC_OFF_CTRL, 32'h2);
    #1 chk(pf, 1'b1);
    chk(irq, 1'b0);
    av(0, CMC_OFF_CTRL, 32'h0);
    chk(q, 32'h3);
    av(1, CMC_OFF_MASK, 32'h1);
    @(posedge ref_clk);
    #1 chk(irq, 1'b1);
    av(0, CMC_OFF_STAT, 32'h0);
    chk(q, 32'h1);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0);
  endtask : t_fault
  task automatic t_normal();
    av(1, CMC_OFF_CTRL, 32'h0);
    acc(rd_op, 4'h1, 8'h11, 1, {df, CMC_EXC});
    acc(rd_op, 4'h1, 8'h11, 0, {dh, CMC_EXC});
    acc(wr_op, 4'h1, 8'h11, 0, {dh, CMC_MOD});
    acc(rd_op, 4'h2, 8'h22, 0, {df, CMC_SHR});
    acc(wr_op, 4'h2, 8'h22, 1, {dhw, CMC_EXC});
    acc(rd_op, 4'h3, 8'h33, 0, {df, CMC_SHR});
    acc(wr_op, 4'h3, 8'h33, 0, {dhw, CMC_SHR});
    acc(wr_op, 4'h4, 8'h44, 0, {dw, CMC_INV});
    acc(sn_op, 4'h3, 8'h33, 0, 6'h3f);
    acc(rd_op, 4'h3, 8'h33, 1, {df, CMC_EXC});
    acc(rd_op, 4'h5, 8'h55, 0, {df, CMC_SHR});
  endtask : t_normal
  task automatic t_cd();
    av(1, CMC_OFF_CTRL, 32'h1);
    acc(rd_op, 4'h6, 8'h66, 1, {d, CMC_INV});
    acc(rd_op, 4'h5, 8'h55, 0, {dh, CMC_SHR});
    acc(wr_op, 4'h5, 8'h55, 0, {dhw, CMC_SHR});
    acc(wr_op, 4'h7, 8'h77, 0, {dw, CMC_INV});
  endtask : t_cd
  task automatic t_both();
    av(1, CMC_OFF_CTRL, 32'h3);
    acc(wr_op, 4'h2, 8'h22, 0, {dh, CMC_MOD});
    acc(wr_op, 4'h5, 8'h55, 1, {dh, CMC_SHR});
    acc(wr_op, 4'h8, 8'h88, 0, {dw, CMC_INV});
    acc(rd_op, 4'h9, 8'h99, 1, {d, CMC_INV});
    acc(sn_op, 4'h5, 8'h55, 0, 6'h3f);
    acc(rd_op, 4'h5, 8'h55, 0, {dh, CMC_SHR});
    chk(ard, 32'h55555555);
  endtask : t_both
  task automatic t_wt();
    @(posedge ref_clk);
    reset <= 1'b1;
    wt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    av(1, CMC_OFF_CTRL, 32'h0);
    acc(rd_op, 4'h1, 8'h11, 1, {df, CMC_SHR});
    acc(wr_op, 4'h1, 8'h11, 0, {dhw, CMC_SHR});
    acc(wr_op, 4'h4, 8'h44, 0, {dw, CMC_INV});
    av(1, CMC_OFF_CTRL, 32'h1);
    acc(wr_op, 4'h1, 8'h11, 0, {dhw, CMC_SHR});
  endtask : t_wt
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_fault();
    t_normal();
    t_cd();
    t_both();
    t_wt();
    give_verdict();
  end
  // whole run is well under a thousand cycles; this only cuts a hang
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule : cache_mode_control_bench
